//--- rtl/eep_consts.svh
// Constants of the serial EEPROM pin front end.
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH
`define EEP_MEM_BYTES   16384
`define EEP_ID_BYTES    64
`define EEP_FIFO_DEPTH  8
`define EEP_CLK_MHZ     100
`define EEP_TW_MS       5
`define EEP_TW_CYC      (`EEP_TW_MS * 1000 * `EEP_CLK_MHZ)
`define EEP_TYPE_POS    4
`define EEP_CS_POS      1
`define EEP_RW_POS      0
`define EEP_LOCK_A_POS  2
`endif

//--- rtl/eep_pkg.sv
// Types shared by the serial EEPROM pin front end.
package eep_pkg;
    typedef enum logic [2:0] {
        EEP_ST_IDLE = 3'b000,
        EEP_ST_RX   = 3'b001,
        EEP_ST_ACK  = 3'b010,
        EEP_ST_TX   = 3'b011,
        EEP_ST_RACK = 3'b100,
        EEP_ST_WCYC = 3'b101
    } eep_state_t;
    typedef enum logic [1:0] {
        EEP_K_DEV  = 2'b00,
        EEP_K_AHI  = 2'b01,
        EEP_K_ALO  = 2'b10,
        EEP_K_DATA = 2'b11
    } eep_kind_t;
    typedef struct packed {
        logic        is_id;
        logic        is_lock;
        logic [13:0] addr;
        logic [7:0]  data;
    } eep_wr_word_t;
    typedef struct packed {
        logic       scl;
        logic       sda;
        logic       wi;
        logic [2:0] cs;
    } eep_pins_t;
endpackage

//--- rtl/eep_fifo.sv
// Flip-flop FIFO with valid/ready on both sides and a flush.
`timescale 1ns/1ns
module eep_fifo #(
    parameter int W = 24,
    parameter int D = 8
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         clr,
    // Fill side.
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Drain side.
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    initial begin
        if (D < 2 || (1 << AW) != D) $error("eep_fifo depth must be a power of two");
    end
    logic [W-1:0] mem_reg [D];
    logic [AW:0]  wp_reg, wp_next, rp_reg, rp_next;
    logic         push, pop;
    assign in_ready  = (wp_reg - rp_reg) != (AW+1)'(D);
    assign out_valid = wp_reg != rp_reg;
    assign out_data  = mem_reg[rp_reg[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_comb begin
        wp_next = clr ? '0 : wp_reg + (AW+1)'(push);
        rp_next = clr ? '0 : rp_reg + (AW+1)'(pop);
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wp_reg[AW-1:0]] <= in_data;
        end
    end
endmodule

//--- rtl/eep_frontend.sv
// Serial EEPROM slave front end: select match, write inhibit, reset and standby.
`timescale 1ns/1ns
`include "eep_consts.svh"
module eep_frontend import eep_pkg::*; #(
    parameter int         MEM_BYTES  = `EEP_MEM_BYTES,
    parameter int         ID_BYTES   = `EEP_ID_BYTES,
    parameter int         FIFO_DEPTH = `EEP_FIFO_DEPTH,
    parameter int         TW_CYC     = `EEP_TW_CYC,
    parameter bit         ID_PAGE_EN = 1'b1,
    // Device type codes; values are arbitrary.
    parameter logic [3:0] ARRAY_TYPE = 4'h5,
    parameter logic [3:0] IDPG_TYPE  = 4'h6
) (
    // Clock and power-on reset.
    input  wire logic mclk,
    input  wire logic arst_n,
    // Serial bus pins.
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    // Strap pins.
    input  wire logic chip_select_pin_2,
    input  wire logic chip_select_pin_1,
    input  wire logic chip_select_pin_0,
    input  wire logic write_inhibit_input,
    // Status.
    output logic      standby,
    output logic      write_busy
);
    initial begin
        if (MEM_BYTES != 16384 || ID_BYTES != 64) $error("eep_frontend size unsupported");
        if (TW_CYC < 1 || TW_CYC >= (1 << 20)) $error("eep_frontend TW_CYC out of range");
    end
    // =====================================================================
    // Pin synchronisers.
    // =====================================================================
    eep_pins_t  raw, s1_reg, s2_reg, s3_reg;
    // Pins reset to their idle bus levels, so that release makes no false edge.
    localparam eep_pins_t PINS_IDLE = '{scl: 1'b1, sda: 1'b1, wi: 1'b0, cs: 3'h0};
    assign raw = '{scl: scl_in, sda: sda_in, wi: write_inhibit_input,
                   cs: {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0}};
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= PINS_IDLE;
            s2_reg <= PINS_IDLE;
            s3_reg <= PINS_IDLE;
        end else begin
            s1_reg <= raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = s2_reg.scl && !s3_reg.scl;
    assign scl_fall  = !s2_reg.scl && s3_reg.scl;
    assign bus_start = s2_reg.scl && s3_reg.scl && s3_reg.sda && !s2_reg.sda;
    assign bus_stop  = s2_reg.scl && s3_reg.scl && !s3_reg.sda && s2_reg.sda;
    // =====================================================================
    // Storage.
    // =====================================================================
    logic [7:0] mem_reg [MEM_BYTES];
    logic [7:0] idp_reg [ID_BYTES];
    logic       locked_reg, locked_next;
    function automatic logic [7:0] rd_byte(input logic id, input logic [13:0] a);
        rd_byte = id ? idp_reg[a[5:0]] : mem_reg[a];
    endfunction
    // =====================================================================
    // Write buffer.
    // =====================================================================
    eep_wr_word_t wr_in, wr_out;
    logic         wr_push, wr_ready, wr_valid, wr_pop, wr_flush;
    eep_fifo #(.W($bits(eep_wr_word_t)), .D(FIFO_DEPTH)) u_wbuf (
        .clk       (mclk),
        .rst_n     (arst_n),
        .clr       (wr_flush),
        .in_valid  (wr_push),
        .in_ready  (wr_ready),
        .in_data   (wr_in),
        .out_valid (wr_valid),
        .out_ready (wr_pop),
        .out_data  (wr_out)
    );
    // =====================================================================
    // Protocol engine.
    // =====================================================================
    eep_state_t  st_reg, st_next;
    eep_kind_t   kind_reg, kind_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [7:0]  sh_reg, sh_next;
    logic [13:0] addr_reg, addr_next;
    logic [19:0] tw_reg, tw_next;
    logic        rw_reg, rw_next, id_reg, id_next, lkreq_reg, lkreq_next;
    logic        ackb_reg, ackb_next, ph_reg, ph_next, dack_reg, dack_next;
    logic        oe_reg, oe_next, sb_reg, sb_next, bz_reg, bz_next;
    logic [7:0]  sh_in;
    logic        sel_ok, data_ok;
    logic [7:0]  rd_cur;
    assign sh_in  = {sh_reg[6:0], s2_reg.sda};
    assign rd_cur = rd_byte(id_reg, addr_reg);
    // Floating strap pins are pulled low, so they compare as zero.
    assign sel_ok = sh_in[`EEP_CS_POS +: 3] == s2_reg.cs &&
                    (sh_in[7:`EEP_TYPE_POS] == ARRAY_TYPE ||
                     (ID_PAGE_EN && sh_in[7:`EEP_TYPE_POS] == IDPG_TYPE));
    // Each data byte looks at the inhibit level of its own eighth bit.
    assign data_ok = !s2_reg.wi && wr_ready && !(id_reg && locked_reg);
    assign wr_in   = '{is_id: id_reg, is_lock: id_reg && lkreq_reg, addr: addr_reg, data: sh_in};
    assign wr_pop  = st_reg == EEP_ST_WCYC;
    always_comb begin
        st_next = st_reg;
        kind_next = kind_reg;
        cnt_next = cnt_reg;
        sh_next = sh_reg;
        addr_next = addr_reg;
        tw_next = tw_reg;
        rw_next = rw_reg;
        id_next = id_reg;
        lkreq_next = lkreq_reg;
        ackb_next = ackb_reg;
        ph_next = ph_reg;
        dack_next = dack_reg;
        oe_next = oe_reg;
        wr_push = 1'b0;
        wr_flush = 1'b0;
        unique case (st_reg)
            EEP_ST_IDLE: begin
                oe_next = 1'b0;
                if (bus_start) begin
                    st_next = EEP_ST_RX;
                    kind_next = EEP_K_DEV;
                    cnt_next = 4'h0;
                end
            end
            EEP_ST_WCYC: begin
                oe_next = 1'b0;
                if (tw_reg >= 20'(TW_CYC - 1) && !wr_valid) begin
                    st_next = EEP_ST_IDLE;
                end else begin
                    tw_next = tw_reg + 20'h00001;
                end
            end
            default: begin
                if (bus_stop) begin
                    oe_next = 1'b0;
                    if (kind_reg == EEP_K_DATA && !rw_reg && dack_reg && wr_valid) begin
                        st_next = EEP_ST_WCYC;
                        tw_next = 20'h00000;
                    end else begin
                        st_next = EEP_ST_IDLE;
                        wr_flush = 1'b1;
                    end
                end else if (bus_start) begin
                    st_next = EEP_ST_RX;
                    kind_next = EEP_K_DEV;
                    cnt_next = 4'h0;
                    oe_next = 1'b0;
                    dack_next = 1'b0;
                    wr_flush = 1'b1;
                end else begin
                    unique case (st_reg)
                        EEP_ST_RX: begin
                            if (scl_rise) begin
                                sh_next = sh_in;
                                cnt_next = cnt_reg + 4'h1;
                                if (cnt_reg == 4'h7) begin
                                    st_next = EEP_ST_ACK;
                                    ph_next = 1'b0;
                                    ackb_next = 1'b1;
                                    unique case (kind_reg)
                                        EEP_K_DEV: begin
                                            rw_next = sh_in[`EEP_RW_POS];
                                            id_next = ID_PAGE_EN &&
                                                      sh_in[7:`EEP_TYPE_POS] == IDPG_TYPE;
                                            if (!sel_ok) begin
                                                st_next = EEP_ST_IDLE;
                                            end
                                        end
                                        EEP_K_AHI: begin
                                            addr_next[13:8] = sh_in[5:0];
                                            lkreq_next = sh_in[`EEP_LOCK_A_POS];
                                        end
                                        EEP_K_ALO: addr_next[7:0] = sh_in;
                                        EEP_K_DATA: begin
                                            ackb_next = data_ok;
                                            wr_push = data_ok;
                                            addr_next[5:0] = addr_reg[5:0] + 6'h01;
                                        end
                                    endcase
                                end
                            end
                        end
                        EEP_ST_ACK: begin
                            if (scl_fall && !ph_reg) begin
                                oe_next = ackb_reg;
                                ph_next = 1'b1;
                            end else if (scl_fall) begin
                                dack_next = kind_reg == EEP_K_DATA && ackb_reg;
                                cnt_next = 4'h0;
                                if (kind_reg == EEP_K_DEV && rw_reg) begin
                                    st_next = EEP_ST_TX;
                                    sh_next = rd_cur;
                                    oe_next = !rd_cur[7];
                                end else begin
                                    st_next = EEP_ST_RX;
                                    oe_next = 1'b0;
                                    kind_next = kind_reg == EEP_K_DATA ? EEP_K_DATA
                                              : eep_kind_t'(kind_reg + 2'b01);
                                end
                            end
                        end
                        EEP_ST_TX: begin
                            if (scl_fall) begin
                                if (cnt_reg == 4'h7) begin
                                    oe_next = 1'b0;
                                    st_next = EEP_ST_RACK;
                                    ph_next = 1'b0;
                                end else begin
                                    oe_next = !sh_reg[6];
                                    sh_next = {sh_reg[6:0], 1'b0};
                                    cnt_next = cnt_reg + 4'h1;
                                end
                            end
                        end
                        EEP_ST_RACK: begin
                            if (scl_rise) begin
                                if (s2_reg.sda) begin
                                    st_next = EEP_ST_IDLE;
                                end else begin
                                    ph_next = 1'b1;
                                    addr_next = addr_reg + 14'h0001;
                                end
                            end else if (scl_fall && ph_reg) begin
                                st_next = EEP_ST_TX;
                                cnt_next = 4'h0;
                                sh_next = rd_cur;
                                oe_next = !rd_cur[7];
                            end
                        end
                        default: st_next = EEP_ST_IDLE;
                    endcase
                end
            end
        endcase
        locked_next = locked_reg || (wr_pop && wr_valid && wr_out.is_lock);
        sb_next = st_next == EEP_ST_IDLE;
        bz_next = st_next == EEP_ST_WCYC;
    end
    // Power-on reset clears the engine registers and the lock but not the array or ID page, and the engine starts in standby.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= EEP_ST_IDLE;
            kind_reg <= EEP_K_DEV;
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            addr_reg <= 14'h0000;
            tw_reg <= 20'h00000;
            rw_reg <= 1'b0;
            id_reg <= 1'b0;
            lkreq_reg <= 1'b0;
            ackb_reg <= 1'b0;
            ph_reg <= 1'b0;
            dack_reg <= 1'b0;
            oe_reg <= 1'b0;
            sb_reg <= 1'b1;
            bz_reg <= 1'b0;
            locked_reg <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            st_reg <= st_next;
            kind_reg <= kind_next;
            cnt_reg <= cnt_next;
            sh_reg <= sh_next;
            addr_reg <= addr_next;
            tw_reg <= tw_next;
            rw_reg <= rw_next;
            id_reg <= id_next;
            lkreq_reg <= lkreq_next;
            ackb_reg <= ackb_next;
            ph_reg <= ph_next;
            dack_reg <= dack_next;
            oe_reg <= oe_next;
            sb_reg <= sb_next;
            bz_reg <= bz_next;
            locked_reg <= locked_next;
            sda_out <= 1'b0;
        end
    end
    // Buffered bytes reach the array only inside the write cycle.
    always_ff @(posedge mclk) begin
        if (wr_pop && wr_valid && !wr_out.is_lock) begin
            if (wr_out.is_id) begin
                idp_reg[wr_out.addr[5:0]] <= wr_out.data;
            end else begin
                mem_reg[wr_out.addr] <= wr_out.data;
            end
        end
    end
    assign sda_oe     = oe_reg;
    assign standby    = sb_reg;
    assign write_busy = bz_reg;
    // =====================================================================
    // Checks.
    // =====================================================================
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    sequence last_bit_s;
        st_reg == EEP_ST_RX && scl_rise && cnt_reg == 4'h7 && !bus_stop && !bus_start;
    endsequence
    sequence stop_s;
        bus_stop && st_reg != EEP_ST_IDLE && st_reg != EEP_ST_WCYC;
    endsequence
    wcyc_release_a: assert property (st_reg == EEP_ST_WCYC |=> !sda_oe)
        else $error("SDA driven during write cycle");
    inhibit_push_a: assert property (wr_push |-> !s2_reg.wi && kind_reg == EEP_K_DATA)
        else $error("write buffered while inhibited");
    sel_miss_a: assert property (last_bit_s and kind_reg == EEP_K_DEV && !sel_ok
        |=> st_reg == EEP_ST_IDLE ##1 standby)
        else $error("mismatched select not deselected");
    wcyc_cause_a: assert property (st_reg != EEP_ST_WCYC ##1 st_reg == EEP_ST_WCYC
        |-> $past(bus_stop) && $past(dack_reg))
        else $error("write cycle without stop after acked data");
    stop_idle_a: assert property (stop_s and !(kind_reg == EEP_K_DATA && dack_reg)
        |=> st_reg == EEP_ST_IDLE ##1 standby)
        else $error("stop did not return to standby");
    data_nack_a: assert property (last_bit_s and kind_reg == EEP_K_DATA && s2_reg.wi
        |=> !ackb_reg ##[1:1000] (st_reg != EEP_ST_ACK || ph_reg) ##0 !sda_oe)
        else $error("data byte acked while inhibited");
    addr_ack_a: assert property (st_reg == EEP_ST_ACK && ph_reg && kind_reg != EEP_K_DATA
        |-> sda_oe)
        else $error("select or address byte not acked");
    ack_level_a: assert property (st_reg == EEP_ST_ACK && ph_reg |-> sda_oe == ackb_reg)
        else $error("acknowledge slot drives wrong level");
    busy_hold_a: assert property (st_reg == EEP_ST_WCYC && bus_start
        |=> st_reg != EEP_ST_RX)
        else $error("start accepted during write cycle");
    pull_only_a: assert property (sda_oe |-> !sda_out)
        else $error("SDA driven high");
endmodule

//--- bench/eep_mst.sv
// Behavioural serial bus master that drives the link clock and pulls the shared data wire.
`timescale 1ns/1ns
module eep_mst (
    // Bus pins.
    output logic      scl,
    output logic      sda_pull,
    input  wire logic sda
);
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // ========================================================
    // Bus steps, one link clock period of 125 ns per bit.
    // Data changes only while the clock is low and is sampled in the high phase.
    // Pin changes sit 1 ns off the step boundary so they never meet a clock edge.
    task automatic slot(input logic lo, output logic seen);
        #1 sda_pull = lo;
        #30 scl = 1'b1;
        #31 seen = sda;
        #32 scl = 1'b0;
        #31;
    endtask
    task automatic start();
        #1 sda_pull = 1'b0;
        #30 scl = 1'b1;
        #31 sda_pull = 1'b1;
        #31 scl = 1'b0;
        #32;
    endtask
    // The clock is left high and still between frames.
    task automatic stop();
        #1 sda_pull = 1'b1;
        #30 scl = 1'b1;
        #31 sda_pull = 1'b0;
        #33;
    endtask
    function automatic logic [7:0] sel(input logic [3:0] t, input logic [2:0] c, input logic r);
        return {t, c, r};
    endfunction
    task automatic put(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) slot(~b[i], s);
        slot(1'b0, s);
        ack = ~s;
    endtask
    task automatic get(input logic lo, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b0, s);
            b[i] = s;
        end
        slot(lo, s);
    endtask
endmodule

//--- bench/tb_top.sv
// Self-checking bench of the serial EEPROM front end against a queue model.
`timescale 1ns/1ns
module tb_top;
    import eep_pkg::*;
    localparam int         TW  = 300;
    localparam logic [3:0] TYP = 4'h5; // Arbitrary type code.
    localparam logic [3:0] IDT = 4'h6; // Arbitrary type code.
    logic       mclk, arst_n, scl, m_pull, sda_wire, sda_out, sda_oe;
    logic       wi, standby, write_busy, ack;
    logic [2:0] cs;
    logic [7:0] rd;
    logic [7:0] mem [int];
    bit         e;
    int         err_count, num_checks, seed, base;

    assign sda_wire = (m_pull || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
    always #5 mclk = ~mclk;

    eep_frontend #(.TW_CYC(TW), .ARRAY_TYPE(TYP), .IDPG_TYPE(IDT)) eep_frontend_inst (
        .mclk(mclk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe(sda_oe), .chip_select_pin_2(cs[2]), .chip_select_pin_1(cs[1]),
        .chip_select_pin_0(cs[0]), .write_inhibit_input(wi), .standby(standby),
        .write_busy(write_busy));
    eep_mst eep_mst_inst (.scl(scl), .sda_pull(m_pull), .sda(sda_wire));

    // ========================================================
    // Comparison and closing.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(negedge mclk) if (sda_oe === 1'b1) chk(8'(sda_out), 8'h00, "drive");

    // ========================================================
    // Transfers checked against the model.
    task automatic pc(input logic [7:0] b, input bit x);
        eep_mst_inst.put(b, ack);
        chk(8'(ack), 8'(x), "ack");
    endtask
    task automatic wr(input int a, input int n, input int wm);
        int q[$];
        bit ok;
        int c;
        eep_mst_inst.start();
        pc(eep_mst_inst.sel(TYP, cs, 1'b0), 1'b1);
        pc(8'(a >> 8), 1'b1);
        pc(8'(a), 1'b1);
        for (int k = 0; k < n; k++) begin
            @(negedge mclk) wi = wm[k];
            rd = 8'($random(seed));
            ok = !wm[k] && k < 8;
            pc(rd, ok);
            if (ok) q.push_back((((a & ~63) | ((a + k) & 63)) << 8) | rd);
        end
        eep_mst_inst.stop();
        c = 0;
        while (ok && write_busy !== 1'b1 && c < 20) begin
            @(negedge mclk);
            c++;
        end
        if (!ok) repeat (20) @(negedge mclk);
        chk(8'(write_busy), 8'(ok), "busy");
        if (!ok) return;
        if (c == 20) end_sim();
        foreach (q[i]) mem[q[i] >> 8] = q[i][7:0];
        eep_mst_inst.start();
        pc(eep_mst_inst.sel(TYP, cs, 1'b0), 1'b0);
        eep_mst_inst.stop();
        chk(8'(write_busy), 8'h01, "long");
        c = 0;
        while (write_busy === 1'b1 && c < TW) begin
            @(negedge mclk);
            c++;
        end
        @(negedge mclk);
        chk({7'h00, standby & ~write_busy}, 8'h01, "idle");
        if (c == TW) end_sim();
    endtask
    task automatic rdchk(input int a, input int n);
        eep_mst_inst.start();
        pc(eep_mst_inst.sel(TYP, cs, 1'b0), 1'b1);
        pc(8'(a >> 8), 1'b1);
        pc(8'(a), 1'b1);
        eep_mst_inst.start();
        pc(eep_mst_inst.sel(TYP, cs, 1'b1), 1'b1);
        for (int k = 0; k < n; k++) begin
            eep_mst_inst.get(k != n - 1, rd);
            chk(rd, mem[a + k], "read");
        end
        eep_mst_inst.stop();
    endtask

    initial begin
        seed = 32'h54d4;
        mclk = 1'b0;
        arst_n = 1'b0;
        wi = 1'b0;
        cs = 3'($random(seed));
        base = $random(seed) & 32'h3FC0;
        repeat (16) @(negedge mclk);
        chk({5'h00, standby, write_busy, sda_oe}, 8'h04, "rst");
        arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        for (int k = 0; k < 9; k++) begin
            e = k < 8 && 3'(k) == cs;
            eep_mst_inst.start();
            pc(eep_mst_inst.sel(k < 8 ? TYP : 4'h0, 3'(k), 1'b0), e);
            repeat (4) @(negedge mclk);
            chk(8'(standby), 8'(!e), "sel");
            eep_mst_inst.stop();
        end
        wr(base, 8, 0);
        rdchk(base, 8);
        wr(base, 4, 'b1010);
        rdchk(base, 8);
        wr(base + 60, 9, 0);
        rdchk(base, 8);
        wr(base + 60, 5, 0);
        rdchk(base + 60, 4);
        rdchk(base, 2);
        // Identification page: write, lock, refused write, then read back.
        for (int j = 0; j < 4; j++) begin
            eep_mst_inst.start();
            pc(eep_mst_inst.sel(IDT, cs, 1'b0), 1'b1);
            pc(j == 1 ? 8'h04 : 8'h00, 1'b1);
            pc(8'h05, 1'b1);
            if (j == 3) break;
            pc(j == 0 ? 8'hA5 : 8'h3C, j < 2);
            eep_mst_inst.stop();
            repeat (TW + 20) @(negedge mclk);
            chk(8'(standby), 8'h01, "idwr");
        end
        eep_mst_inst.start();
        pc(eep_mst_inst.sel(IDT, cs, 1'b1), 1'b1);
        eep_mst_inst.get(1'b0, rd);
        chk(rd, 8'hA5, "idpage");
        eep_mst_inst.stop();
        @(negedge mclk) arst_n = 1'b0;
        eep_mst_inst.start();
        pc(eep_mst_inst.sel(TYP, cs, 1'b0), 1'b0);
        eep_mst_inst.stop();
        @(negedge mclk) arst_n = 1'b1;
        repeat (4) @(negedge mclk);
        chk({5'h00, standby, write_busy, sda_oe}, 8'h04, "por");
        rdchk(base, 8);
        end_sim();
    end
endmodule
